/* dv/cpu_tail_host.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_tail_host (
    // Clock
    input  wire logic        clk_in,
    // Bus towards the core
    input  wire logic        wait_in,
    input  wire logic [31:0] rdata_in,
    output logic      [3:0]  addr_out,
    output logic             rd_out,
    output logic             wr_out,
    output logic      [31:0] wdata_out
);
    // The bus is idle from time zero.
    initial begin
        addr_out  = 4'h0;
        rd_out    = 1'b0;
        wr_out    = 1'b0;
        wdata_out = 32'h0;
    end
    // Waitrequest and read data are taken at the rising edge, as the slave sees them there.
    // The request stands until that edge; a slave that never answers is cut by the watchdog.
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_in);
        addr_out  <= a;
        wr_out    <= wr;
        rd_out    <= ~wr;
        wdata_out <= d;
        do begin
            @(posedge clk_in);
        end while (wait_in !== 1'b0);
        q = rdata_in;
        rd_out <= 1'b0;
        wr_out <= 1'b0;
    endtask
endmodule // cpu_tail_host
`default_nettype wire

/* dv/test_cpu_tail_opcode_execution.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpu_tail_defs.svh"
module test_cpu_tail_opcode_execution;
    logic        clk_in;
    logic        resetn_in;
    logic [3:0]  addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    logic        irq_out;
    logic [31:0] q[$];
    logic [7:0]  pq[$];
    logic [31:0] rv;
    logic [7:0]  r1, r2, r3;
    integer      seed, errors, num_checks, i;

    cpu_tail_core u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(addr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .irq_out(irq_out));
    cpu_tail_host u_host (.clk_in(clk_in), .wait_in(waitreq), .rdata_in(rdata),
        .addr_out(addr), .rd_out(rd_en), .wr_out(wr_en), .wdata_out(wdata));

    // Clock at 200 MHz.
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Every completed read while an expectation is pending meets the oldest one the driver noted.
    always @(posedge clk_in) begin
        if (rd_en && waitreq === 1'b0 && q.size() > 0) chk("readdata", rdata, q.pop_front());
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rv);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        q.push_back(e);
        u_host.xfer(1'b0, a, 32'h0, rv);
    endtask
    task automatic poke(input logic [7:0] a, input logic [7:0] d);
        wr(`RG_MEM_ADDR, {24'h0, a});
        wr(`RG_MEM_DATA, {24'h0, d});
    endtask
    task automatic peek(input logic [7:0] a, input logic [7:0] e);
        wr(`RG_MEM_ADDR, {24'h0, a});
        rd(`RG_MEM_DATA, {24'h0, e});
    endtask
    // Loads the byte queue as a program; each one ends on an opcode the core refuses.
    task automatic go(input logic [7:0] base);
        integer n;
        for (n = 0; n < pq.size(); n++) poke(base + n[7:0], pq[n]);
        wr(`RG_PC, {24'h0, base});
        wr(`RG_CTRL, 32'h1);
        n = 0;
        do begin
            u_host.xfer(1'b0, `RG_CTRL, 32'h0, rv);
            n++;
        end while (rv[0] !== 1'b0 && n < 64);
        chk("halt", {31'h0, rv[0]}, 32'h0);
        @(negedge clk_in);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog, well past the few hundred cycles the sequence needs.
    initial begin
        #200000;
        errors++;
        test_done();
    end
    // Main sequence.
    initial begin
        seed = 32'h932bdd81;
        errors = 0;
        num_checks = 0;
        resetn_in = 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(`RG_SP, 32'h0000_00ff);
        rd(`RG_STATUS, 32'h0000_6800);
        wr(4'hf, 32'h5a);
        rd(4'hf, 32'h0);
        // Test a negative A, move flags into A and X, and move X through the stack pointer.
        wr(`RG_SP, 32'h50);
        wr(`RG_CORE, 32'h0012_3480);
        pq = '{8'h4d, 8'h85, 8'h94, 8'h97, 8'h95, 8'h9f, 8'h42};
        go(8'h00);
        rd(`RG_STATUS, 32'h0000_6c00);
        rd(`RG_CORE, 32'h0012_3434);
        rd(`RG_SP, 32'h0000_1233);
        rd(`RG_IRQ_STAT, 32'h2);
        // Flags from A, then a trap whose stack frame and vector are checked.
        wr(`RG_IRQ_CLR, 32'h3);
        wr(`RG_IRQ_EN, 32'h1);
        wr(`RG_SP, 32'h80);
        wr(`RG_CORE, 32'h0000_4001);
        poke(8'hfc, 8'h00);
        poke(8'hfd, 8'h20);
        poke(8'h20, 8'h42);
        pq = '{8'h84, 8'h83};
        go(8'h10);
        chk("irq", {31'h0, irq_out}, 32'h1);
        rd(`RG_SP, 32'h7b);
        rd(`RG_STATUS, 32'h0000_0900);
        rd(`RG_PC, 32'h20);
        pq = '{8'h12, 8'h00, 8'h40, 8'h01, 8'h01};
        for (i = 0; i < 5; i++) peek(8'h80 - i[7:0], pq[i]);
        wr(`RG_IRQ_EN, 32'h0);
        @(negedge clk_in);
        chk("irq", {31'h0, irq_out}, 32'h0);
        wr(`RG_IRQ_CLR, 32'h3);
        rd(`RG_IRQ_STAT, 32'h0);
        // Extended, stack short and immediate-to-direct modes on random bytes.
        r1 = $random(seed);
        r2 = $random(seed);
        r3 = $random(seed);
        wr(`RG_SP, 32'h40);
        wr(`RG_CORE, 32'h0);
        poke(8'h55, r1);
        poke(8'h45, r2);
        pq = '{8'hc6, 8'h00, 8'h55, 8'h97, 8'h9e, 8'he6, 8'h05, 8'h6e, r3, 8'h60, 8'h42};
        go(8'h30);
        rd(`RG_CORE, {16'h0, r1, r2});
        peek(8'h60, r3);
        // A long offset load, then post-increment moves and compare walk the index pair; each memory test form sees 80.
        wr(`RG_CORE, 32'h0000_5000);
        poke(8'h50, r1);
        poke(8'h52, 8'h00);
        poke(8'h53, 8'h80);
        poke(8'h70, r3);
        pq = '{8'hd6, 8'h00, 8'h20, 8'h7e, 8'h58, 8'h5e, 8'h58, 8'h71, 8'h00, 8'h7d,
               8'h6d, 8'h00, 8'h3d, 8'h53, 8'h9e, 8'h6d, 8'h13, 8'h42};
        go(8'h90);
        rd(`RG_CORE, {8'h00, 16'h0053, r3});
        rd(`RG_STATUS, 32'h0000_0d00);
        peek(8'h58, r1);
        peek(8'h51, r1);
        test_done();
    end
endmodule // test_cpu_tail_opcode_execution
`default_nettype wire

/* rtl/cpu_tail_core.sv */
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_tail_defs.svh"
module cpu_tail_core #(
    parameter int          MEM_AW      = 8,
    parameter logic [15:0] TRAP_VECTOR = 16'hfffc
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Interrupt
    output logic             irq_out
);
    ////////////////////////////////////////////////////////////////////////
    localparam int NWR = 5;
    cpu_tail_pkg::cpu_regs_t   regs_ff, nxt_regs;
    cpu_tail_pkg::core_state_t state_ff;
    cpu_tail_pkg::mem_wr_t     wr [NWR];
    logic [7:0]  mem_ff [2**MEM_AW];
    logic [3:0]  wait_ff, cyc;
    logic        run_ff, ack_ff, illegal, trap, exec;
    logic [1:0]  irq_stat_ff, irq_en_ff;
    logic [15:0] mem_addr_ff;
    logic [31:0] rdata_ff;
    logic [7:0]  b0, b1, b2, b3, op, opb1, opb2, tv;
    logic        pre;
    logic [15:0] ea, ret;

    // Memory is a flop array, so every operand byte is visible in one cycle.
    function automatic logic [7:0] rd(input logic [15:0] a);
        return mem_ff[a[MEM_AW-1:0]];
    endfunction

    // Loads and tests clear overflow and update negative and zero only.
    function automatic logic [7:0] nz(input logic [7:0] f, input logic [7:0] v);
        logic [7:0] r;
        r          = f;
        r[`CCR_V]  = 1'b0;
        r[`CCR_N]  = v[7];
        r[`CCR_Z]  = (v == 8'h00);
        return r;
    endfunction

    assign exec = (state_ff == cpu_tail_pkg::ST_EXEC);

    ////////////////////////////////////////////////////////////////////////
    // Decode and execute: each instruction commits in its first cycle and
    // the sequencer then pads out the documented cycle count.
    always_comb begin
        b0      = rd(regs_ff.pc);
        b1      = rd(regs_ff.pc + 16'h0001);
        b2      = rd(regs_ff.pc + 16'h0002);
        b3      = rd(regs_ff.pc + 16'h0003);
        pre     = (b0 == `OP_PREBYTE);
        op      = pre ? b1 : b0;
        opb1    = pre ? b2 : b1;
        opb2    = pre ? b3 : b2;
        nxt_regs = regs_ff;
        cyc     = `CYC_ONE;
        illegal = 1'b0;
        trap    = 1'b0;
        ea      = 16'h0000;
        tv      = 8'h00;
        ret     = regs_ff.pc + 16'h0001;
        for (int i = 0; i < NWR; i++) begin
            wr[i] = '0;
        end
        unique case ({pre, op})
            {1'b0, `OP_TRAP}: begin
                // Return address, index low, A and flags go down the stack.
                wr[0] = '{1'b1, regs_ff.sp, ret[7:0]};
                wr[1] = '{1'b1, regs_ff.sp - 16'h0001, ret[15:8]};
                wr[2] = '{1'b1, regs_ff.sp - 16'h0002, regs_ff.hx[7:0]};
                wr[3] = '{1'b1, regs_ff.sp - 16'h0003, regs_ff.acc};
                wr[4] = '{1'b1, regs_ff.sp - 16'h0004, regs_ff.flag_register};
                nxt_regs.sp          = regs_ff.sp - `PUSH_BYTES;
                nxt_regs.flag_register[`CCR_I] = 1'b1;
                nxt_regs.pc = {rd(TRAP_VECTOR), rd(TRAP_VECTOR + 16'h0001)};
                cyc  = `CYC_TRAP;
                trap = 1'b1;
            end
            {1'b0, `OP_ACC_TO_FLG}: begin
                nxt_regs.flag_register = regs_ff.acc;
                nxt_regs.pc  = ret;
                cyc          = `CYC_TAP;
            end
            {1'b0, `OP_FLG_TO_ACC}: begin
                nxt_regs.acc = regs_ff.flag_register;
                nxt_regs.pc  = ret;
            end
            {1'b0, `OP_ACC_TO_IDX}: begin
                nxt_regs.hx[7:0] = regs_ff.acc;
                nxt_regs.pc      = ret;
            end
            {1'b0, `OP_IDX_TO_ACC}: begin
                nxt_regs.acc = regs_ff.hx[7:0];
                nxt_regs.pc  = ret;
            end
            {1'b0, `OP_TST_DIR}: begin
                tv           = rd({8'h00, opb1});
                nxt_regs.flag_register = nz(regs_ff.flag_register, tv);
                nxt_regs.pc  = regs_ff.pc + 16'h0002;
                cyc          = `CYC_THREE;
            end
            {1'b0, `OP_TST_ACC}: begin
                nxt_regs.flag_register = nz(regs_ff.flag_register, regs_ff.acc);
                nxt_regs.pc  = ret;
            end
            {1'b0, `OP_TST_IDX}: begin
                nxt_regs.flag_register = nz(regs_ff.flag_register, regs_ff.hx[7:0]);
                nxt_regs.pc  = ret;
            end
            {1'b0, `OP_TST_IX1}: begin
                tv           = rd(regs_ff.hx + {8'h00, opb1});
                nxt_regs.flag_register = nz(regs_ff.flag_register, tv);
                nxt_regs.pc  = regs_ff.pc + 16'h0002;
                cyc          = `CYC_THREE;
            end
            {1'b0, `OP_TST_IX}: begin
                tv           = rd(regs_ff.hx);
                nxt_regs.flag_register = nz(regs_ff.flag_register, tv);
                nxt_regs.pc  = ret;
                cyc          = `CYC_TWO;
            end
            {1'b1, `OP_TST_IX1}: begin
                ea           = regs_ff.sp + {8'h00, opb1};
                tv           = rd(ea);
                nxt_regs.flag_register = nz(regs_ff.flag_register, tv);
                nxt_regs.pc  = regs_ff.pc + 16'h0003;
                cyc          = `CYC_FOUR;
            end
            {1'b0, `OP_STK_TO_IDX}: begin
                nxt_regs.hx = regs_ff.sp + 16'h0001;
                nxt_regs.pc = ret;
                cyc         = `CYC_TWO;
            end
            {1'b0, `OP_IDX_TO_STK}: begin
                nxt_regs.sp = regs_ff.hx - 16'h0001;
                nxt_regs.pc = ret;
                cyc         = `CYC_TWO;
            end
            {1'b0, `OP_LDA_EXT}: begin
                ea           = {opb1, opb2};
                nxt_regs.acc = rd(ea);
                nxt_regs.flag_register = nz(regs_ff.flag_register, rd(ea));
                nxt_regs.pc  = regs_ff.pc + 16'h0003;
                cyc          = `CYC_FOUR;
            end
            {1'b0, `OP_LDA_IX2}: begin
                ea           = regs_ff.hx + {opb1, opb2};
                nxt_regs.acc = rd(ea);
                nxt_regs.flag_register = nz(regs_ff.flag_register, rd(ea));
                nxt_regs.pc  = regs_ff.pc + 16'h0003;
                cyc          = `CYC_FOUR;
            end
            {1'b1, `OP_LDA_SP1}: begin
                ea           = regs_ff.sp + {8'h00, opb1};
                nxt_regs.acc = rd(ea);
                nxt_regs.flag_register = nz(regs_ff.flag_register, rd(ea));
                nxt_regs.pc  = regs_ff.pc + 16'h0003;
                cyc          = `CYC_FOUR;
            end
            {1'b0, `OP_CBEQ_IXP}: begin
                // Compare A with the byte at the index pair, branch if equal.
                tv          = rd(regs_ff.hx);
                nxt_regs.hx = regs_ff.hx + 16'h0001;
                nxt_regs.pc = regs_ff.pc + 16'h0002 +
                              ((tv == regs_ff.acc) ? {{8{opb1[7]}}, opb1} : 16'h0000);
                cyc         = `CYC_FOUR;
            end
            {1'b0, `OP_MOV_DIXP}: begin
                tv           = rd({8'h00, opb1});
                wr[0]        = '{1'b1, regs_ff.hx, tv};
                nxt_regs.hx  = regs_ff.hx + 16'h0001;
                nxt_regs.flag_register = nz(regs_ff.flag_register, tv);
                nxt_regs.pc  = regs_ff.pc + 16'h0002;
                cyc          = `CYC_FOUR;
            end
            {1'b0, `OP_MOV_IMD}: begin
                wr[0]        = '{1'b1, {8'h00, opb2}, opb1};
                nxt_regs.flag_register = nz(regs_ff.flag_register, opb1);
                nxt_regs.pc  = regs_ff.pc + 16'h0003;
                cyc          = `CYC_FOUR;
            end
            {1'b0, `OP_MOV_IXPD}: begin
                tv           = rd(regs_ff.hx);
                wr[0]        = '{1'b1, {8'h00, opb1}, tv};
                nxt_regs.hx  = regs_ff.hx + 16'h0001;
                nxt_regs.flag_register = nz(regs_ff.flag_register, tv);
                nxt_regs.pc  = regs_ff.pc + 16'h0002;
                cyc          = `CYC_FOUR;
            end
            default: begin
                illegal = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: EXEC commits, WAIT pads the instruction to its cycle count.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_ff <= cpu_tail_pkg::ST_IDLE;
            wait_ff  <= 4'h0;
        end else begin
            unique case (state_ff)
                cpu_tail_pkg::ST_IDLE: begin
                    if (run_ff) begin
                        state_ff <= cpu_tail_pkg::ST_EXEC;
                    end
                end
                cpu_tail_pkg::ST_EXEC: begin
                    wait_ff <= cyc - 4'h1;
                    if (illegal) begin
                        state_ff <= cpu_tail_pkg::ST_IDLE;
                    end else if (cyc != `CYC_ONE) begin
                        state_ff <= cpu_tail_pkg::ST_WAIT;
                    end else if (!run_ff) begin
                        state_ff <= cpu_tail_pkg::ST_IDLE;
                    end
                end
                cpu_tail_pkg::ST_WAIT: begin
                    wait_ff <= wait_ff - 4'h1;
                    if (wait_ff == 4'h1) begin
                        state_ff <= run_ff ? cpu_tail_pkg::ST_EXEC : cpu_tail_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, then the access completes.
    logic wr_go, rd_go;
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
    assign wr_go               = avs_write_in & ack_ff;
    assign rd_go               = avs_read_in & ~ack_ff;
    assign avs_readdata_out    = rdata_ff;
    assign irq_out             = |(irq_stat_ff & irq_en_ff);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
            if (rd_go) begin
                unique case (avs_address_in)
                    `RG_CTRL:     rdata_ff <= {31'h0, run_ff};
                    `RG_STATUS:   rdata_ff <= {16'h0, regs_ff.flag_register, 7'h0,
                                               state_ff != cpu_tail_pkg::ST_IDLE};
                    `RG_PC:       rdata_ff <= {16'h0, regs_ff.pc};
                    `RG_SP:       rdata_ff <= {16'h0, regs_ff.sp};
                    `RG_CORE:     rdata_ff <= {8'h0, regs_ff.hx, regs_ff.acc};
                    `RG_MEM_ADDR: rdata_ff <= {16'h0, mem_addr_ff};
                    `RG_MEM_DATA: rdata_ff <= {24'h0, rd(mem_addr_ff)};
                    `RG_IRQ_STAT: rdata_ff <= {30'h0, irq_stat_ff};
                    `RG_IRQ_EN:   rdata_ff <= {30'h0, irq_en_ff};
                    default:      rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Run control: software starts the core, an unknown opcode stops it.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            run_ff      <= 1'b0;
            mem_addr_ff <= 16'h0000;
        end else begin
            if (exec && illegal) begin
                run_ff <= 1'b0;
            end else if (wr_go && avs_address_in == `RG_CTRL) begin
                run_ff <= avs_writedata_in[0];
            end
            if (wr_go && avs_address_in == `RG_MEM_ADDR) begin
                mem_addr_ff <= avs_writedata_in[15:0];
            end
        end
    end

    // Sticky events: bit 0 trap taken, bit 1 unknown opcode; set beats clear.
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_stat_ff <= 2'h0;
            irq_en_ff   <= 2'h0;
        end else begin
            irq_stat_ff <= (irq_stat_ff & ~((wr_go && avs_address_in == `RG_IRQ_CLR) ?
                            avs_writedata_in[1:0] : 2'h0)) | {exec & illegal, exec & trap};
            if (wr_go && avs_address_in == `RG_IRQ_EN) begin
                irq_en_ff <= avs_writedata_in[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core registers; software may load them only while the core is idle,
    // so a running program never sees them change under it.
    logic idle;
    assign idle = (state_ff == cpu_tail_pkg::ST_IDLE) && !run_ff;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            regs_ff <= '{`RST_PC, `RST_SP, 16'h0000, 8'h00, `RST_CCR};
        end else if (exec && !illegal) begin
            regs_ff <= nxt_regs;
        end else if (wr_go && idle) begin
            if (avs_address_in == `RG_PC) begin
                regs_ff.pc <= avs_writedata_in[15:0];
            end
            if (avs_address_in == `RG_SP) begin
                regs_ff.sp <= avs_writedata_in[15:0];
            end
            if (avs_address_in == `RG_CORE) begin
                regs_ff.acc <= avs_writedata_in[7:0];
                regs_ff.hx  <= avs_writedata_in[23:8];
            end
        end
    end

    // Memory: instruction writes when executing, software writes when idle.
    always_ff @(posedge clk_in) begin
        if (exec && !illegal) begin
            for (int i = 0; i < NWR; i++) begin
                if (wr[i].en) begin
                    mem_ff[wr[i].addr[MEM_AW-1:0]] <= wr[i].data;
                end
            end
        end else if (wr_go && idle && avs_address_in == `RG_MEM_DATA) begin
            mem_ff[mem_addr_ff[MEM_AW-1:0]] <= avs_writedata_in[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [8:0] key;
    assign key = {pre, op};

    a_trap_stack: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key == {1'b0, `OP_TRAP} |=> regs_ff.sp == $past(regs_ff.sp) - `PUSH_BYTES
        && regs_ff.flag_register[`CCR_I]) else $error("trap did not push or mask");
    a_trap_cycles: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key == {1'b0, `OP_TRAP} |=> (state_ff == cpu_tail_pkg::ST_WAIT)[*8]
        ##1 state_ff != cpu_tail_pkg::ST_WAIT) else $error("trap length wrong");
    a_acc_to_flags: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key == {1'b0, `OP_ACC_TO_FLG} |=> regs_ff.flag_register == $past(regs_ff.acc)
        && state_ff == cpu_tail_pkg::ST_WAIT ##1 state_ff != cpu_tail_pkg::ST_WAIT)
        else $error("flag load wrong");
    a_flags_to_acc: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key == {1'b0, `OP_FLG_TO_ACC} |=> regs_ff.acc == $past(regs_ff.flag_register)
        && $stable(regs_ff.flag_register)) else $error("flag read wrong");
    a_acc_to_idx: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key == {1'b0, `OP_ACC_TO_IDX} |=> regs_ff.hx[7:0] == $past(regs_ff.acc)
        && $stable(regs_ff.flag_register)) else $error("index load wrong");
    a_test_flags: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && !illegal && op[3:0] == 4'hd && op[7:4] inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7}
        |=> !regs_ff.flag_register[`CCR_V] && regs_ff.flag_register[`CCR_C] == $past(regs_ff.flag_register[`CCR_C])
        && regs_ff.flag_register[`CCR_H] == $past(regs_ff.flag_register[`CCR_H])
        && regs_ff.flag_register[`CCR_I] == $past(regs_ff.flag_register[`CCR_I])) else $error("test flags");
    a_test_sp_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key == {1'b1, `OP_TST_IX1} |=> (state_ff == cpu_tail_pkg::ST_WAIT)[*3]
        ##1 state_ff != cpu_tail_pkg::ST_WAIT) else $error("stack test length");
    a_stack_to_idx: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key == {1'b0, `OP_STK_TO_IDX} |=> regs_ff.hx == $past(regs_ff.sp) + 16'h0001)
        else $error("stack to index wrong");
    a_idx_to_stack: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key == {1'b0, `OP_IDX_TO_STK} |=> regs_ff.sp == $past(regs_ff.hx) - 16'h0001)
        else $error("index to stack wrong");
    a_postinc_idx: assert property (@(posedge clk_in) disable iff (!resetn_in)
        exec && key inside {{1'b0, `OP_CBEQ_IXP}, {1'b0, `OP_MOV_IXPD}, {1'b0, `OP_MOV_DIXP}}
        |=> regs_ff.hx == $past(regs_ff.hx) + 16'h0001) else $error("no post increment");
endmodule // cpu_tail_core
`default_nettype wire

/* rtl/cpu_tail_defs.svh */
`ifndef CPU_TAIL_DEFS_SVH
`define CPU_TAIL_DEFS_SVH
// Overview of operation
// - Trap: push PC, index low, A, flags; mask; vector
// - Opcode 84 copies accumulator into flags, 2 cycles
// - Opcode 85 copies flags into accumulator, 1 cycle
// - Opcodes 97/9F move accumulator and index low byte
// - Test clears overflow, sets negative and zero only
// - Test opcodes 3D,4D,5D,6D,7D,9E6D with cycle counts
// - Opcode 95 loads index pair with stack plus one
// - Opcode 94 loads stack with index pair minus one
// - Stack short mode adds unsigned byte to stack
// - Long indexed mode adds 16-bit offset to index
// - Extended mode fetches address high byte first
// - Post-increment mode uses index, then increments it
// - Direct-to-indexed move, then index increments
// - Immediate byte written to direct page location
// - Indexed byte moved to direct page, index increments
// - Pre-byte selects stack addressing instead of indexed

// Opcodes (low byte; stack forms follow the pre-byte).
`define OP_PREBYTE     8'h9e
`define OP_TRAP        8'h83
`define OP_ACC_TO_FLG  8'h84
`define OP_FLG_TO_ACC  8'h85
`define OP_ACC_TO_IDX  8'h97
`define OP_IDX_TO_ACC  8'h9f
`define OP_TST_DIR     8'h3d
`define OP_TST_ACC     8'h4d
`define OP_TST_IDX     8'h5d
`define OP_TST_IX1     8'h6d
`define OP_TST_IX      8'h7d
`define OP_STK_TO_IDX  8'h95
`define OP_IDX_TO_STK  8'h94
`define OP_LDA_EXT     8'hc6
`define OP_LDA_IX2     8'hd6
`define OP_LDA_SP1     8'he6
`define OP_CBEQ_IXP    8'h71
`define OP_MOV_DIXP    8'h5e
`define OP_MOV_IMD     8'h6e
`define OP_MOV_IXPD    8'h7e

// Cycle counts per instruction.
`define CYC_TRAP       4'h9
`define CYC_TAP        4'h2
`define CYC_ONE        4'h1
`define CYC_TWO        4'h2
`define CYC_THREE      4'h3
`define CYC_FOUR       4'h4

// Flag bit positions.
`define CCR_V          7
`define CCR_H          4
`define CCR_I          3
`define CCR_N          2
`define CCR_Z          1
`define CCR_C          0

// Register word indices on the bus.
`define RG_CTRL        4'h0
`define RG_STATUS      4'h1
`define RG_PC          4'h2
`define RG_SP          4'h3
`define RG_CORE        4'h4
`define RG_MEM_ADDR    4'h5
`define RG_MEM_DATA    4'h6
`define RG_IRQ_STAT    4'h7
`define RG_IRQ_CLR     4'h8
`define RG_IRQ_EN      4'h9

// Reset values and the number of bytes a trap pushes.
`define RST_SP         16'h00ff
`define RST_PC         16'h0000
`define RST_CCR        8'h68
`define PUSH_BYTES     16'h0005
`endif

/* rtl/cpu_tail_pkg.sv */
package cpu_tail_pkg;
    // Sequencer states.
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} core_state_t;
    // One memory write produced by an instruction.
    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [7:0]  data;
    } mem_wr_t;
    // Programmer-visible register set.
    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] hx;
        logic [7:0]  acc;
        logic [7:0]  flag_register;
    } cpu_regs_t;
endpackage
